/* nvmcc_ctrl.v */
// Nonvolatile memory command controller with APB register access.
`default_nettype none
`include "nvmcc_defs.vh"
// Overview of operation
// - Command execute bit starts action commands.
// - Memory read starts loaded read command.
// - Software execute-bit and byte-write triggers need prior unlock sequence; read and load triggers do not.
// - Busy flag set during executed CRC and programming commands.
// - Busy blocks command, control, address, data writes.
// - Programming blocks loads, erases, external reads.
// - External programmer cannot write calibration row.
// - Software writes lock bits only more restrictive.
// - Boot section fetches continue during application writes.
// - Flash by page; EEPROM by byte or page.
// - Flash buffer loaded one word per load.
// - Unloaded flash buffer words read all ones.
// - Flash buffer erased after reset and page commands.
// - EEPROM buffer loaded one byte per load.
// - Each loaded EEPROM buffer location gets tagged.
// - EEPROM page operations touch tagged locations only.
// - EEPROM buffer and tags cleared after page write, lock and fuse commands.
// - CRC over whole flash or one section.
// - Separate locks for external and self access.
module nvmcc_ctrl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire ext_access,
   input wire boot_fetch,
   output reg cpu_halt
);
   // Arrays: flash, EEPROM, flash and EEPROM buffers, flash load marks, EEPROM tags.
   // Flash array, one 16-bit word per location.
   reg [15:0] flash_mem [0:255];
   // Flash page buffer, one word per page location.
   reg [15:0] fbuf [0:15];
   // EEPROM page buffer, one byte per page location.
   reg [7:0] ebuf [0:15];
   // One tag per EEPROM buffer byte that has been loaded.
   reg [15:0] etag_reg;
   // One mark per flash buffer word that has been loaded.
   reg [15:0] fload_reg;
   // EEPROM array, one byte per location.
   reg [7:0] eep_mem [0:255];
   // Software visible registers.
   // Memory address: space, page and word in page.
   reg [23:0] addr_reg;
   // Data register, also the result of a memory read command.
   reg [15:0] data_reg;
   // Loaded command code.
   reg [6:0] cmd_reg;
   // Second control register, stored only.
   reg [7:0] ctrlb_reg;
   // Lock bits; a set bit allows the access.
   reg [7:0] lock_reg;
   // Fuse byte.
   reg [7:0] fuse_reg;
   // User signature word.
   reg [15:0] sig_reg;
   // Running checksum.
   reg [15:0] crc_reg;
   // Operation state.
   // High while an operation runs.
   reg busy_reg;
   // Cycles left of a programming operation.
   reg [7:0] cnt_reg;
   // Command captured when the operation started.
   reg [6:0] op_reg;
   // Next flash word for the checksum.
   reg [8:0] crc_idx_reg;
   // Cycles left in the unlock window.
   reg [3:0] unlock_reg;
   // Two-stage synchroniser for the external master pin.
   reg [1:0] ext_sync_reg;
   // Loop index of the command process.
   integer i;
   // Loop index of the array process.
   integer j;
   // Word index inside the page.
   wire [3:0] widx = addr_reg[3:0];
   // Memory space selected by the address.
   wire [3:0] space = addr_reg[23:20];
   // External programmer owns the controller.
   wire ext = ext_sync_reg[1];
   // Write and read in the access phase.
   wire wr_go = psel & penable & pwrite;
   wire rd_go = psel & penable & ~pwrite;
   // Triggers are open to the external master or inside the window.
   wire unlocked = ext | (unlock_reg != 4'h0);
   // The flash word index lies in the boot section.
   wire in_boot = addr_reg[7:0] >= `NVMCC_BOOT_START;
   // CRC-16 step over one word.
   function [15:0] crc_step;
      input [15:0] c;
      input [15:0] d;
      integer k;
      reg [15:0] r;
      begin
         r = c;
         for (k = 0; k < 16; k = k + 1) begin
            r = r[15] ^ d[15 - k] ? {r[14:0], 1'b0} ^ 16'h1021
               : {r[14:0], 1'b0};
         end
         crc_step = r;
      end
   endfunction
   // Lock check: external uses bit 1, self uses section bits.
   function allowed_wr;
      input e;
      input [7:0] lk;
      input boot;
      begin
         if (e) begin
            allowed_wr = lk[1];
         end else begin
            allowed_wr = boot ? lk[3] : lk[5];
         end
      end
   endfunction
   // Whether a command programs memory.
   function is_prog;
      input [6:0] c;
      begin
         is_prog = (c >= `NVMCC_C_WR_FPAGE) && (c <= `NVMCC_C_WR_EBYTE);
      end
   endfunction
   // A single EEPROM byte write, taken at the answering edge; it is
   // decoded here so that only the array process writes the EEPROM.
   wire ebyte_go = wr_go && pready && !busy_reg &&
      paddr == `NVMCC_MEM_OFS && cmd_reg == `NVMCC_C_WR_EBYTE &&
      unlocked && space == `NVMCC_SP_EEP &&
      allowed_wr(ext, lock_reg, 1'b0);
   // Read data path; memory reads give zero while busy.
   reg [31:0] rd_val;
   always @* begin
      rd_val = 32'h00000000;
      case (paddr)
         `NVMCC_ADDR_OFS: rd_val = {8'h00, addr_reg};
         `NVMCC_DATA_OFS: rd_val = {16'h0000, data_reg};
         `NVMCC_CMD_OFS: rd_val = {25'h0000000, cmd_reg};
         `NVMCC_CTRLB_OFS: rd_val = {24'h000000, ctrlb_reg};
         `NVMCC_STATUS_OFS: rd_val = {29'h00000000, etag_reg != 16'h0,
            fload_reg != 16'h0, busy_reg};
         `NVMCC_LOCK_OFS: rd_val = {24'h000000, lock_reg};
         `NVMCC_CRC_OFS: rd_val = {16'h0000, crc_reg};
         `NVMCC_MEM_OFS: begin
            if (busy_reg) begin
               rd_val = 32'h00000000;
            end else if (!ext && !boot_fetch && !lock_reg[4]) begin
               rd_val = 32'h00000000;
            end else begin
               case (space)
                  `NVMCC_SP_FLASH:
                     rd_val = {16'h0000, flash_mem[addr_reg[7:0]]};
                  `NVMCC_SP_EEP:
                     rd_val = {24'h000000, eep_mem[addr_reg[7:0]]};
                  `NVMCC_SP_SIG: rd_val = {16'h0000, sig_reg};
                  `NVMCC_SP_FUSE: rd_val = {24'h000000, fuse_reg};
                  default: rd_val = 32'h00000000;
               endcase
            end
         end
         default: rd_val = 32'h00000000;
      endcase
   end
   // APB answer: one access cycle, error on offsets above the CRC register.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         cpu_halt <= 1'b0;
         ext_sync_reg <= 2'b00;
      end else begin
         ext_sync_reg <= {ext_sync_reg[0], ext_access};
         // Answer in the cycle after setup, then drop for one cycle.
         pready <= psel & ~pready;
         pslverr <= psel & ~pready & (paddr > `NVMCC_CRC_OFS);
         prdata <= rd_val;
         // Halt only while a programming command of any space runs at a word index in the boot range, or on the signature space.
         cpu_halt <= busy_reg & is_prog(op_reg) &
            (in_boot | space == `NVMCC_SP_SIG);
      end
   end
   // Commands, buffers and memories.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= 24'h000000;
         data_reg <= 16'h0000;
         cmd_reg <= `NVMCC_C_NOP;
         ctrlb_reg <= 8'h00;
         lock_reg <= `NVMCC_LOCK_RESET;
         fuse_reg <= 8'hff;
         sig_reg <= 16'hffff;
         crc_reg <= `NVMCC_CRC_INIT;
         busy_reg <= 1'b0;
         cnt_reg <= 8'h00;
         op_reg <= `NVMCC_C_NOP;
         crc_idx_reg <= 9'h000;
         unlock_reg <= 4'h0;
         etag_reg <= 16'h0000;
         fload_reg <= 16'h0000;
         for (i = 0; i < 16; i = i + 1) begin
            fbuf[i] <= `NVMCC_FBUF_ERASED;
            ebuf[i] <= `NVMCC_EBUF_ERASED;
         end
      end else begin
         // The unlock window closes by itself.
         if (unlock_reg != 4'h0) begin
            unlock_reg <= unlock_reg - 4'h1;
         end
         if (wr_go && pready && paddr == `NVMCC_UNLOCK_OFS &&
            pwdata[7:0] == `NVMCC_UNLOCK_KEY) begin
            unlock_reg <= `NVMCC_UNLOCK_CYC;
         end
         // Register writes, frozen while busy.
         if (wr_go && pready && !busy_reg) begin
            case (paddr)
               `NVMCC_ADDR_OFS: addr_reg <= pwdata[23:0];
               `NVMCC_DATA_OFS: data_reg <= pwdata[15:0];
               `NVMCC_CMD_OFS: cmd_reg <= pwdata[6:0];
               `NVMCC_CTRLB_OFS: ctrlb_reg <= pwdata[7:0];
               `NVMCC_CONTROL_A_REGISTER_OFS: begin
                  // Action commands need unlock from software.
                  if (pwdata[`NVMCC_COMMAND_EXECUTE_BIT_BIT] && unlocked) begin
                     if (cmd_reg == `NVMCC_C_CRC_ALL ||
                        cmd_reg == `NVMCC_C_CRC_SECT) begin
                        busy_reg <= 1'b1;
                        op_reg <= cmd_reg;
                        crc_reg <= `NVMCC_CRC_INIT;
                        // A boot section run starts at the section's word.
                        crc_idx_reg <= (cmd_reg == `NVMCC_C_CRC_SECT &&
                           in_boot) ? {1'b0, `NVMCC_BOOT_START} : 9'h000;
                     end else if (is_prog(cmd_reg) &&
                        allowed_wr(ext, lock_reg, in_boot)) begin
                        busy_reg <= 1'b1;
                        op_reg <= cmd_reg;
                        cnt_reg <= `NVMCC_PROG_CYC;
                     end else if (cmd_reg == `NVMCC_C_ERASE_FBUF) begin
                        fload_reg <= 16'h0000;
                        for (i = 0; i < 16; i = i + 1) begin
                           fbuf[i] <= `NVMCC_FBUF_ERASED;
                        end
                     end else if (cmd_reg == `NVMCC_C_ERASE_EBUF) begin
                        etag_reg <= 16'h0000;
                     end
                  end
               end
               `NVMCC_LOCK_OFS: begin
                  // Software can only clear lock bits.
                  if (ext) begin
                     lock_reg <= pwdata[7:0];
                  end else if (unlocked) begin
                     lock_reg <= lock_reg & pwdata[7:0];
                  end
               end
               `NVMCC_MEM_OFS: begin
                  // Memory write triggers the loaded write command.
                  if (cmd_reg == `NVMCC_C_LOAD_FBUF) begin
                     fbuf[widx] <= fload_reg[widx] ?
                        fbuf[widx] & pwdata[15:0] : pwdata[15:0];
                     fload_reg[widx] <= 1'b1;
                  end else if (cmd_reg == `NVMCC_C_LOAD_EBUF) begin
                     ebuf[widx] <= etag_reg[widx] ?
                        ebuf[widx] & pwdata[7:0] : pwdata[7:0];
                     etag_reg[widx] <= 1'b1;
                  end
                  // A byte write command lands in the array process.
                  // Calibration row is never writable.
                  if (space == `NVMCC_SP_CAL) begin
                     data_reg <= data_reg;
                  end
               end
               default: begin
                  data_reg <= data_reg;
               end
            endcase
         end
         // Memory read triggers the loaded read command.
         if (rd_go && pready && !busy_reg && paddr == `NVMCC_MEM_OFS &&
            cmd_reg == `NVMCC_C_READ) begin
            data_reg <= rd_val[15:0];
         end
         // Running operation.
         if (busy_reg) begin
            if (op_reg == `NVMCC_C_CRC_ALL || op_reg == `NVMCC_C_CRC_SECT)
               begin
               crc_reg <= crc_step(crc_reg, flash_mem[crc_idx_reg[7:0]]);
               crc_idx_reg <= crc_idx_reg + 9'h001;
               if (crc_idx_reg[7:0] == 8'hff ||
                  (op_reg == `NVMCC_C_CRC_SECT && !in_boot &&
                  crc_idx_reg[7:0] == `NVMCC_BOOT_START - 8'h01)) begin
                  busy_reg <= 1'b0;
               end
            end else if (cnt_reg != 8'h00) begin
               cnt_reg <= cnt_reg - 8'h01;
            end else begin
               busy_reg <= 1'b0;
               case (op_reg)
                  `NVMCC_C_WR_FPAGE, `NVMCC_C_EW_FPAGE, `NVMCC_C_WR_SIG,
                  `NVMCC_C_WR_LOCK: begin
                     fload_reg <= 16'h0000;
                     for (i = 0; i < 16; i = i + 1) begin
                        fbuf[i] <= `NVMCC_FBUF_ERASED;
                     end
                  end
                  default: fload_reg <= fload_reg;
               endcase
               case (op_reg)
                  `NVMCC_C_WR_EPAGE, `NVMCC_C_EW_EPAGE,
                  `NVMCC_C_WR_LOCK, `NVMCC_C_WR_FUSE: begin
                     etag_reg <= 16'h0000;
                     for (i = 0; i < 16; i = i + 1) begin
                        ebuf[i] <= `NVMCC_EBUF_ERASED;
                     end
                  end
                  default: etag_reg <= etag_reg;
               endcase
               if (op_reg == `NVMCC_C_WR_SIG) begin
                  sig_reg <= fbuf[0];
               end
               if (op_reg == `NVMCC_C_WR_FUSE && ext) begin
                  fuse_reg <= data_reg[7:0];
               end
               if (op_reg == `NVMCC_C_WR_LOCK) begin
                  lock_reg <= lock_reg & data_reg[7:0];
               end
            end
         end
      end
   end
   // Byte writes at once and page programming at completion into the memory arrays.
   // The arrays have no reset: their content is what was programmed.
   always @(posedge pclk) begin
      // A single EEPROM byte lands as soon as its write is answered.
      if (presetn && ebyte_go) begin
         eep_mem[addr_reg[7:0]] <= pwdata[7:0];
      end
      // Page operations act in the last cycle of the operation.
      if (presetn && busy_reg && cnt_reg == 8'h00) begin
         for (j = 0; j < 16; j = j + 1) begin
            // Whole flash page, unloaded words program ones.
            if (op_reg == `NVMCC_C_WR_FPAGE ||
               op_reg == `NVMCC_C_EW_FPAGE) begin
               flash_mem[{addr_reg[7:4], j[3:0]}] <= fbuf[j];
            end
            // EEPROM page: tagged locations only.
            if (etag_reg[j]) begin
               if (op_reg == `NVMCC_C_WR_EPAGE ||
                  op_reg == `NVMCC_C_EW_EPAGE) begin
                  eep_mem[{addr_reg[7:4], j[3:0]}] <= ebuf[j];
               end else if (op_reg == `NVMCC_C_ER_EPAGE) begin
                  eep_mem[{addr_reg[7:4], j[3:0]}] <= `NVMCC_EBUF_ERASED;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* nvmcc_ctrl_asserts.sv */
// Checker for bus handshake, error response and halt timing.
`default_nettype none
module nvmcc_ctrl_asserts (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire ext_access,
   input wire boot_fetch,
   input wire cpu_halt
);
   // Counts consecutive halted cycles; a page program takes 33 cycles.
   logic [6:0] halt_cnt;
   // The counter restarts whenever the halt drops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_cnt <= 7'h00;
      end else if (cpu_halt) begin
         halt_cnt <= halt_cnt + 7'h01;
      end else begin
         halt_cnt <= 7'h00;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A setup cycle followed by access gets its answer one cycle later.
   sequence s_setup_access;
      psel && !penable ##1 psel && penable;
   endsequence
   a_ready_after_setup: assert property (s_setup_access |-> pready)
      else $error("ready missing after setup and access");
   a_ready_no_wait: assert property (psel && penable |-> pready)
      else $error("ready missing in access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready stayed high");
   a_ready_idle: assert property (!psel |=> !pready)
      else $error("ready without access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_err_unmapped: assert property (psel && !penable
      && paddr > 12'h024 |=> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (psel && !penable
      && paddr <= 12'h024 |=> !pslverr)
      else $error("error on mapped address");
   a_halt_bounded: assert property (halt_cnt <= 7'h30)
      else $error("processor halted too long");
   // Main scenarios reached.
   c_err: cover property (pslverr);
   c_halt: cover property ($rose(cpu_halt));
   c_write: cover property (pready && pwrite);
endmodule
bind nvmcc_ctrl nvmcc_ctrl_asserts nvmcc_ctrl_asserts_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ext_access(ext_access), .boot_fetch(boot_fetch),
   .cpu_halt(cpu_halt));
`default_nettype wire

/* nvmcc_ctrl_test.sv */
// Self-checking bench for the nonvolatile memory command controller.
`default_nettype none
`include "nvmcc_defs.vh"
module nvmcc_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, ext_access, boot_fetch;
   wire psel, penable, pwrite, pready, pslverr, cpu_halt;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   int err_count, checks;
   nvmcc_ctrl nvmcc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_access(ext_access), .boot_fetch(boot_fetch), .cpu_halt(cpu_halt));
   nvmcc_host nvmcc_host_i (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready));
   // Compares one value and counts the result.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic give_verdict();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Loads a command and a memory address.
   task automatic cmd(input logic [6:0] c, input logic [23:0] a);
      nvmcc_host_i.wr(`NVMCC_CMD_OFS, {25'h0, c});
      nvmcc_host_i.wr(`NVMCC_ADDR_OFS, {8'h00, a});
   endtask
   // Writes the command execute bit.
   task automatic exec();
      nvmcc_host_i.wr(`NVMCC_CONTROL_A_REGISTER_OFS, 32'h00000001);
   endtask
   // Loads one buffer location through a memory write.
   task automatic ld(input logic [6:0] c, input logic [23:0] a,
      input logic [31:0] d);
      cmd(c, a);
      nvmcc_host_i.wr(`NVMCC_MEM_OFS, d);
   endtask
   // Reads one memory location through a read command.
   task automatic rdmem(input logic [23:0] a, output logic [31:0] r);
      cmd(`NVMCC_C_READ, a);
      nvmcc_host_i.rd(`NVMCC_MEM_OFS, r);
   endtask
   // Polls busy under a bound and notes whether the processor halted.
   task automatic wait_idle(output logic halted);
      logic [31:0] s;
      halted = 1'b0;
      for (int i = 0; i < 200; i++) begin
         nvmcc_host_i.rd(`NVMCC_STATUS_OFS, s);
         if (cpu_halt === 1'b1) halted = 1'b1;
         if (s[0] === 1'b0) break;
      end
   endtask
   // Status after reset, plus an unmapped read.
   task automatic t_reset();
      logic [31:0] r;
      nvmcc_host_i.xfer(1'b0, `NVMCC_STATUS_OFS, 32'h00000000, r);
      chk({31'h0, pslverr}, 32'h00000000);
      nvmcc_host_i.rel();
      chk(r, 32'h00000000);
      nvmcc_host_i.xfer(1'b0, 12'h028, 32'h00000000, r);
      chk({31'h0, pslverr}, 32'h00000001);
      nvmcc_host_i.rel();
   endtask
   // Flash page program with blocked accesses while busy.
   task automatic t_flash(input logic [3:0] pg, input logic hexp);
      logic [31:0] r;
      logic h;
      boot_fetch <= ~hexp;
      ld(`NVMCC_C_LOAD_FBUF, {16'h0, pg, 4'h2}, 32'h00001234);
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r & 32'h2, 32'h2);
      cmd(`NVMCC_C_WR_FPAGE, {16'h0, pg, 4'h0});
      exec();
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r & 32'h1, 32'h1);
      nvmcc_host_i.wr(`NVMCC_CMD_OFS, 32'h00000000);
      nvmcc_host_i.rd(`NVMCC_MEM_OFS, r);
      chk(r, 32'h00000000);
      nvmcc_host_i.rd(`NVMCC_CMD_OFS, r);
      chk(r & 32'h7f, {25'h0, `NVMCC_C_WR_FPAGE});
      wait_idle(h);
      chk({31'h0, h}, {31'h0, hexp});
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r, 32'h00000000);
      rdmem({16'h0, pg, 4'h2}, r);
      chk(r, 32'h00001234);
      rdmem({16'h0, pg, 4'h3}, r);
      chk(r, 32'h0000ffff);
   endtask
   // Two EEPROM page programs; the second must spare the first's byte.
   task automatic t_eeprom();
      logic [31:0] r;
      logic h;
      ld(`NVMCC_C_LOAD_EBUF, 24'h100005, 32'h0000005a);
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r & 32'h4, 32'h4);
      cmd(`NVMCC_C_WR_EPAGE, 24'h100000);
      exec();
      wait_idle(h);
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r, 32'h00000000);
      ld(`NVMCC_C_LOAD_EBUF, 24'h100001, 32'h00000011);
      cmd(`NVMCC_C_EW_EPAGE, 24'h100000);
      exec();
      wait_idle(h);
      rdmem(24'h100005, r);
      chk(r, 32'h0000005a);
      rdmem(24'h100001, r);
      chk(r, 32'h00000011);
   endtask
   // Software trigger ignored without unlock, taken right after it.
   task automatic t_unlock();
      logic [31:0] r;
      logic h;
      ext_access <= 1'b0;
      repeat (4) @(posedge pclk);
      cmd(`NVMCC_C_CRC_ALL, 24'h000000);
      exec();
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r & 32'h1, 32'h0);
      nvmcc_host_i.xfer(1'b1, `NVMCC_UNLOCK_OFS, 32'h0000009d, r);
      nvmcc_host_i.xfer(1'b1, `NVMCC_CONTROL_A_REGISTER_OFS, 32'h00000001, r);
      nvmcc_host_i.rel();
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r & 32'h1, 32'h1);
      wait_idle(h);
      nvmcc_host_i.rd(`NVMCC_STATUS_OFS, r);
      chk(r & 32'h1, 32'h0);
   endtask
   // Clock at 125 MHz.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      give_verdict();
   end
   // Reset for six cycles, then every scenario in turn.
   initial begin
      presetn = 1'b0;
      ext_access = 1'b1;
      boot_fetch = 1'b0;
      err_count = 0;
      checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_flash(4'h0, 1'b0);
      t_flash(4'hc, 1'b1);
      t_eeprom();
      t_unlock();
      give_verdict();
   end
endmodule
`default_nettype wire

/* nvmcc_defs.vh */
// Constants for the nonvolatile memory command controller.
`ifndef NVMCC_DEFS_VH
`define NVMCC_DEFS_VH
// Register byte offsets on the APB bus.
`define NVMCC_ADDR_OFS 12'h000
`define NVMCC_DATA_OFS 12'h004
`define NVMCC_CMD_OFS 12'h008
`define NVMCC_CONTROL_A_REGISTER_OFS 12'h00c
`define NVMCC_CTRLB_OFS 12'h010
`define NVMCC_STATUS_OFS 12'h014
`define NVMCC_LOCK_OFS 12'h018
`define NVMCC_UNLOCK_OFS 12'h01c
`define NVMCC_MEM_OFS 12'h020
`define NVMCC_CRC_OFS 12'h024
// Field positions.
`define NVMCC_COMMAND_EXECUTE_BIT_BIT 0
`define NVMCC_BUSY_BIT 0
`define NVMCC_FBUF_BIT 1
`define NVMCC_EBUF_BIT 2
`define NVMCC_EXT_BIT 0
// Unlock key written to the unlock register.
`define NVMCC_UNLOCK_KEY 8'h9d
// Unlock window in cycles.
`define NVMCC_UNLOCK_CYC 4'h4
// Reset values.
`define NVMCC_FBUF_ERASED 16'hffff
`define NVMCC_EBUF_ERASED 8'hff
`define NVMCC_LOCK_RESET 8'hff
`define NVMCC_CRC_INIT 16'hffff
// Commands.
`define NVMCC_C_NOP 7'h00
`define NVMCC_C_READ 7'h01
`define NVMCC_C_LOAD_FBUF 7'h02
`define NVMCC_C_LOAD_EBUF 7'h03
`define NVMCC_C_ERASE_FBUF 7'h04
`define NVMCC_C_ERASE_EBUF 7'h05
`define NVMCC_C_WR_FPAGE 7'h06
`define NVMCC_C_EW_FPAGE 7'h07
`define NVMCC_C_WR_SIG 7'h08
`define NVMCC_C_WR_LOCK 7'h09
`define NVMCC_C_WR_FUSE 7'h0a
`define NVMCC_C_WR_EPAGE 7'h0b
`define NVMCC_C_EW_EPAGE 7'h0c
`define NVMCC_C_ER_EPAGE 7'h0d
`define NVMCC_C_WR_EBYTE 7'h0e
`define NVMCC_C_CRC_ALL 7'h0f
`define NVMCC_C_CRC_SECT 7'h10
// Memory space select in address bits [23:20].
`define NVMCC_SP_FLASH 4'h0
`define NVMCC_SP_EEP 4'h1
`define NVMCC_SP_SIG 4'h2
`define NVMCC_SP_CAL 4'h3
`define NVMCC_SP_FUSE 4'h4
// Section boundary inside flash (word index).
`define NVMCC_BOOT_START 8'hc0
// Programming duration in cycles.
`define NVMCC_PROG_CYC 8'h20
`define NVMCC_FLASH_WORDS 9'h100
`endif

/* nvmcc_host.sv */
// Bus master model standing in for software or the external programmer.
`default_nettype none
module nvmcc_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready
);
   timeunit 1ns;
   timeprecision 1ps;
   // The bus is idle at time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // One transfer, entered just after an edge; select stays high so a
   // further transfer may follow with no gap.
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
   endtask
   // Releases the bus; stale write data is inverted so it cannot linger.
   task automatic rel();
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata;
      @(posedge pclk);
   endtask
   // Single write.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
      rel();
   endtask
   // Single read.
   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h00000000, r);
      rel();
   endtask
endmodule
`default_nettype wire
